// ===== common/bit_exec_pkg.sv
`default_nettype none

package bit_exec_pkg;

  // instruction word layout
  localparam int WORD_W         = 14;
  localparam int PC_W           = 13;
  localparam int FILE_W         = 7;
  localparam int FILE_LSB       = 0;
  localparam int BIT_W          = 3;
  localparam int BIT_LSB        = 7;
  localparam int LIT_W          = 8;
  localparam int LIT_LSB        = 0;
  localparam int TARGET_W       = 11;
  localparam int TARGET_LSB     = 0;
  localparam int LATCH_W        = 5;
  localparam int PAGE_W         = 2;
  localparam int LATCH_PAGE_LSB = 3;
  localparam int DATA_W         = 8;

  // opcode fields, matched from the top of the word
  localparam logic [3:0]        OPC_BIT_CLEAR  = 4'h4;
  localparam logic [3:0]        OPC_BIT_SET    = 4'h5;
  localparam logic [3:0]        OPC_SKIP_CLEAR = 4'h6;
  localparam logic [3:0]        OPC_SKIP_SET   = 4'h7;
  localparam logic [5:0]        OPC_AND_LIT    = 6'h39;
  localparam logic [2:0]        OPC_CALL       = 3'h4;
  localparam logic [6:0]        OPC_ZERO_FILE  = 7'h03;
  localparam logic [6:0]        OPC_ZERO_ACC   = 7'h02;
  localparam logic [WORD_W-1:0] OPC_KICK       = 14'h0064;

  // hardware stack
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;

  // reset values
  localparam logic [PC_W-1:0]    RESET_PC     = 13'h0000;
  localparam logic [DATA_W-1:0]  RESET_ACC    = 8'h00;
  localparam logic [LATCH_W-1:0] RESET_LATCH  = 5'h00;
  localparam logic               RESET_NULL   = 1'b0;
  localparam logic               RESET_EXPIRY = 1'b1;
  localparam logic               RESET_SLEEP  = 1'b1;
  localparam logic [DATA_W-1:0]  ZERO_BYTE    = 8'h00;

  // register bus map, byte addresses
  localparam int             BUS_AW        = 5;
  localparam logic [BUS_AW-1:0] REG_ACC    = 5'h00;
  localparam logic [BUS_AW-1:0] REG_FLAGS  = 5'h04;
  localparam logic [BUS_AW-1:0] REG_FETCH  = 5'h08;
  localparam logic [BUS_AW-1:0] REG_LATCH  = 5'h0c;
  localparam logic [BUS_AW-1:0] REG_STACK  = 5'h10;
  localparam int FLAG_NULL_BIT   = 0;
  localparam int FLAG_EXPIRY_BIT = 1;
  localparam int FLAG_SLEEP_BIT  = 2;
  localparam int STACK_LEVEL_LSB = 16;

  typedef enum logic [3:0] {
    op_none, op_bit_clear, op_bit_set, op_skip_clear, op_skip_set,
    op_and_lit, op_zero_file, op_zero_acc, op_call, op_kick
  } op_t;

endpackage

`default_nettype wire

// ===== common/file_port_if.sv
`timescale 1ns/10ps
`default_nettype none

interface file_port_if;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic       wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;

  modport core  (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
  modport store (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

`default_nettype wire

// ===== rtl/bit_literal_call_exec.sv
`timescale 1ns/10ps
`default_nettype none

module bit_literal_call_exec
  import bit_exec_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              instr_valid,
  input  wire logic [WORD_W-1:0] instr_word,
  input  wire logic              stack_pop,
  input  wire logic              sleep_entered,
  input  wire logic              dog_timeout,
  input  wire logic [BUS_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic      [PC_W-1:0]   fetch_pointer,
  output logic      [DATA_W-1:0] accumulator,
  output logic      [PC_W-1:0]   stack_head,
  output logic                   dog_clear,
  output logic                   result_null_flag,
  output logic                   dog_expiry_flag,
  output logic                   sleep_entry_flag
);

  file_port_if file_bus ();

  file_store file_store_inst (
    .clock (clock),
    .rst_n (rst_n),
    .port  (file_bus)
  );

  logic              stage_valid;
  logic [WORD_W-1:0] stage_word;
  logic [PC_W-1:0]   stage_pc;
  op_t               stage_op;
  logic [LATCH_W-1:0]     upper_program_latch;
  logic [PC_W-1:0]        stack_mem [0:STACK_DEPTH-1];
  logic [STACK_PTR_W-1:0] stack_level;
  logic              tested_bit;
  logic              skip_taken;
  logic              call_taken;
  logic              take_word;
  logic              kick_taken;
  logic              file_write;
  logic [DATA_W-1:0] next_file;
  logic [DATA_W-1:0] and_result;
  logic [PC_W-1:0]   return_addr;
  logic [PC_W-1:0]   call_target;
  logic              bus_take;
  logic              bus_wr;
  logic [31:0]       read_value;
  logic [31:0]       write_value;

  function automatic op_t decode_op(input logic [WORD_W-1:0] w);
    op_t op;
    op = op_none;
    if (w == OPC_KICK)
      op = op_kick;
    else if (w[WORD_W-1 -: 7] == OPC_ZERO_FILE)
      op = op_zero_file;
    else if (w[WORD_W-1 -: 7] == OPC_ZERO_ACC)
      op = op_zero_acc;
    else if (w[WORD_W-1 -: 6] == OPC_AND_LIT)
      op = op_and_lit;
    else if (w[WORD_W-1 -: 3] == OPC_CALL)
      op = op_call;
    else
      case (w[WORD_W-1 -: 4])
        OPC_BIT_CLEAR:  op = op_bit_clear;
        OPC_BIT_SET:    op = op_bit_set;
        OPC_SKIP_CLEAR: op = op_skip_clear;
        OPC_SKIP_SET:   op = op_skip_set;
        default:        op = op_none;
      endcase
    return op;
  endfunction

  function automatic logic [DATA_W-1:0] put_bit(input logic [DATA_W-1:0] v,
                                                input logic [BIT_W-1:0]  idx,
                                                input logic              b);
    logic [DATA_W-1:0] r;
    r      = v;
    r[idx] = b;
    return r;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // execute stage decisions
  always_comb
  begin
    tested_bit  = file_bus.rd_data[stage_word[BIT_LSB +: BIT_W]];
    skip_taken  = stage_valid
                  && ((stage_op == op_skip_set && tested_bit)
                  || (stage_op == op_skip_clear && !tested_bit));
    call_taken  = stage_valid && stage_op == op_call;
    kick_taken  = stage_valid && stage_op == op_kick;
    take_word   = instr_valid && !skip_taken && !call_taken;
    and_result  = accumulator & stage_word[LIT_LSB +: LIT_W];
    return_addr = PC_W'(stage_pc + 1'b1);
    call_target = {upper_program_latch[LATCH_PAGE_LSB +: PAGE_W],
                   stage_word[TARGET_LSB +: TARGET_W]};
    next_file   = file_bus.rd_data;
    file_write  = 1'b0;
    case (stage_op)
      op_bit_clear:
      begin
        next_file  = put_bit(file_bus.rd_data, stage_word[BIT_LSB +: BIT_W], 1'b0);
        file_write = stage_valid;
      end
      op_bit_set:
      begin
        next_file  = put_bit(file_bus.rd_data, stage_word[BIT_LSB +: BIT_W], 1'b1);
        file_write = stage_valid;
      end
      op_zero_file:
      begin
        next_file  = ZERO_BYTE;
        file_write = stage_valid;
      end
      default: file_write = 1'b0;
    endcase
  end

  assign file_bus.rd_addr = instr_word[FILE_LSB +: FILE_W];
  assign file_bus.wr_en   = file_write;
  assign file_bus.wr_addr = stage_word[FILE_LSB +: FILE_W];
  assign file_bus.wr_data = next_file;

  // fetch to execute stage; a redirected slot becomes an empty cycle
  always_ff @(posedge clock)
  begin
    stage_valid <= rst_n && take_word;
    stage_word  <= instr_word;
    stage_pc    <= fetch_pointer;
    stage_op    <= decode_op(instr_word);
  end

  // fetch pointer
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      fetch_pointer <= RESET_PC;
    end
    else if (bus_wr && avs_address == REG_FETCH)
    begin
      fetch_pointer <= write_value[PC_W-1:0];
    end
    else if (call_taken)
    begin
      fetch_pointer <= call_target;
    end
    else if (skip_taken || take_word)
    begin
      fetch_pointer <= PC_W'(fetch_pointer + 1'b1);
    end
  end

  // accumulator
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      accumulator <= RESET_ACC;
    end
    else if (bus_wr && avs_address == REG_ACC)
    begin
      accumulator <= write_value[DATA_W-1:0];
    end
    else if (stage_valid && stage_op == op_and_lit)
    begin
      accumulator <= and_result;
    end
    else if (stage_valid && stage_op == op_zero_acc)
    begin
      accumulator <= ZERO_BYTE;
    end
  end

  // result null flag, hardware update wins over a bus write
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      result_null_flag <= RESET_NULL;
    end
    else if (stage_valid && stage_op == op_and_lit)
    begin
      result_null_flag <= (and_result == ZERO_BYTE);
    end
    else if (stage_valid && (stage_op == op_zero_file || stage_op == op_zero_acc))
    begin
      result_null_flag <= 1'b1;
    end
    else if (bus_wr && avs_address == REG_FLAGS)
    begin
      result_null_flag <= write_value[FLAG_NULL_BIT];
    end
  end

  // watchdog status flags, the kick wins over any clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      dog_expiry_flag <= RESET_EXPIRY;
    end
    else if (kick_taken)
    begin
      dog_expiry_flag <= 1'b1;
    end
    else if (dog_timeout)
    begin
      dog_expiry_flag <= 1'b0;
    end
    else if (bus_wr && avs_address == REG_FLAGS)
    begin
      dog_expiry_flag <= write_value[FLAG_EXPIRY_BIT];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sleep_entry_flag <= RESET_SLEEP;
    end
    else if (kick_taken)
    begin
      sleep_entry_flag <= 1'b1;
    end
    else if (sleep_entered)
    begin
      sleep_entry_flag <= 1'b0;
    end
    else if (bus_wr && avs_address == REG_FLAGS)
    begin
      sleep_entry_flag <= write_value[FLAG_SLEEP_BIT];
    end
  end

  // one-cycle clear for the dog counter and its prescaler
  always_ff @(posedge clock)
  begin
    dog_clear <= rst_n && kick_taken;
  end

  // upper program latch, written by software
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      upper_program_latch <= RESET_LATCH;
    end
    else if (bus_wr && avs_address == REG_LATCH)
    begin
      upper_program_latch <= write_value[LATCH_W-1:0];
    end
  end

  // circular hardware stack; a push wins over a pop
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      stack_level <= '0;
      stack_head  <= RESET_PC;
      for (int i = 0; i < STACK_DEPTH; i++)
      begin
        stack_mem[i] <= RESET_PC;
      end
    end
    else if (call_taken)
    begin
      stack_level <= STACK_PTR_W'(stack_level + 1'b1);
      stack_mem[STACK_PTR_W'(stack_level + 1'b1)] <= return_addr;
      stack_head  <= return_addr;
    end
    else if (stack_pop)
    begin
      stack_level <= STACK_PTR_W'(stack_level - 1'b1);
      stack_head  <= stack_mem[STACK_PTR_W'(stack_level - 1'b1)];
    end
  end

  // register bus slave: one wait cycle, then the answer
  assign bus_take    = (avs_read || avs_write) && avs_waitrequest;
  assign bus_wr      = avs_write && !avs_waitrequest;
  assign write_value = be_merge(read_value, avs_writedata, avs_byteenable);

  always_comb
  begin
    read_value = '0;
    case (avs_address)
      REG_ACC:   read_value = 32'(accumulator);
      REG_FLAGS:
      begin
        read_value[FLAG_NULL_BIT]   = result_null_flag;
        read_value[FLAG_EXPIRY_BIT] = dog_expiry_flag;
        read_value[FLAG_SLEEP_BIT]  = sleep_entry_flag;
      end
      REG_FETCH: read_value = 32'(fetch_pointer);
      REG_LATCH: read_value = 32'(upper_program_latch);
      REG_STACK:
      begin
        read_value[PC_W-1:0] = stack_head;
        read_value[STACK_LEVEL_LSB +: STACK_PTR_W] = stack_level;
      end
      default:   read_value = '0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end
    else
    begin
      avs_waitrequest <= !bus_take;
      if (bus_take && avs_read)
      begin
        avs_readdata <= read_value;
      end
    end
  end

endmodule // bit_literal_call_exec

`default_nettype wire

// ===== rtl/file_store.sv
`timescale 1ns/10ps
`default_nettype none

module file_store
  import bit_exec_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst_n,
  file_port_if.store port
);

  logic [DATA_W-1:0] mem [0:(1<<FILE_W)-1];

  // write port
  always_ff @(posedge clock)
  begin
    if (port.wr_en)
    begin
      mem[port.wr_addr] <= port.wr_data;
    end
  end

  // registered read, a same-cycle write is passed through
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      port.rd_data <= ZERO_BYTE;
    end
    else if (port.wr_en && port.wr_addr == port.rd_addr)
    begin
      port.rd_data <= port.wr_data;
    end
    else
    begin
      port.rd_data <= mem[port.rd_addr];
    end
  end

endmodule // file_store

`default_nettype wire

// ===== test/bit_exec_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module bit_exec_asserts
  import bit_exec_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              instr_valid,
  input wire logic [WORD_W-1:0] instr_word,
  input wire logic [PC_W-1:0]   fetch_pointer,
  input wire logic [DATA_W-1:0] accumulator,
  input wire logic [PC_W-1:0]   stack_head,
  input wire logic              dog_clear,
  input wire logic              result_null_flag,
  input wire logic              dog_expiry_flag,
  input wire logic              sleep_entry_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic call_now;
  assign call_now = instr_valid && instr_word[13:11] == OPC_CALL;

  a_kick_source: assert property (
    dog_clear |-> $past(instr_valid, 2) && $past(instr_word, 2) == OPC_KICK)
    else $error("dog clear without kick");
  a_kick_flags: assert property (
    dog_clear |-> dog_expiry_flag && sleep_entry_flag)
    else $error("kick flags not set");
  a_kick_once: assert property (
    $rose(dog_clear) |=> !dog_clear)
    else $error("dog clear longer than one cycle");
  a_call_push: assert property (
    call_now |=> ##1 stack_head == PC_W'($past(fetch_pointer, 2) + 1'b1))
    else $error("call pushed wrong return");
  a_call_low: assert property (
    call_now |=> ##1 fetch_pointer[10:0] == $past(instr_word[10:0], 2))
    else $error("call target low bits wrong");
  a_call_flags: assert property (
    call_now |=> ##1 $stable(result_null_flag) && $stable(dog_expiry_flag)
      && $stable(sleep_entry_flag))
    else $error("call altered a flag");
  a_call_third: assert property (
    (call_now ##2 instr_valid) |=> fetch_pointer == PC_W'($past(fetch_pointer) + 1'b1))
    else $error("target word not taken in third slot");
  a_zero_acc: assert property (
    instr_valid && instr_word[13:7] == OPC_ZERO_ACC |=> ##1
      accumulator == 8'h00 && result_null_flag)
    else $error("zero accumulator failed");
  a_zero_file: assert property (
    instr_valid && instr_word[13:7] == OPC_ZERO_FILE |=> ##1 result_null_flag)
    else $error("zero file left null flag low");
endmodule // bit_exec_asserts

bind bit_literal_call_exec bit_exec_asserts bit_exec_asserts_inst (.*);

`default_nettype wire

// ===== test/test_bit_literal_call_exec.sv
`timescale 1ns/10ps
`default_nettype none

module test_bit_literal_call_exec
  import bit_exec_pkg::*;
;
  logic              clock, rst_n, instr_valid, stack_pop, sleep_entered, dog_timeout;
  logic [WORD_W-1:0] instr_word;
  logic [BUS_AW-1:0] avs_address;
  logic              avs_read, avs_write, avs_waitrequest, dog_clear;
  logic [31:0]       avs_writedata, avs_readdata;
  logic [3:0]        avs_byteenable;
  logic [PC_W-1:0]   fetch_pointer, stack_head;
  logic [DATA_W-1:0] accumulator, ra, lit;
  logic              result_null_flag, dog_expiry_flag, sleep_entry_flag;
  int                bad_count, checks_done, seed, kicks;
  logic [31:0]       exp_q[$];
  logic [6:0]        f;
  logic [2:0]        b;
  logic [12:0]       pc0;
  logic [12:0]       ret1;
  logic [4:0]        lat;
  logic [10:0]       k;

  bit_literal_call_exec bit_literal_call_exec_inst (.*);

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic step(input logic [WORD_W-1:0] w);
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(posedge clock);
  endtask

  task automatic idle;
    instr_valid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [BUS_AW-1:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [BUS_AW-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [BUS_AW-1:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  // result monitors
  always @(posedge clock)
    if (avs_read && avs_waitrequest === 1'b0)
      check_word("readdata", exp_q.pop_front(), avs_readdata);

  always @(posedge clock)
    if (rst_n && dog_clear !== 1'b0)
    begin
      check_word("dog_clear", {31'h0, kicks > 0}, {31'h0, dog_clear});
      kicks--;
    end

  initial
  begin
    repeat (5000) @(posedge clock);
    bad_count++;
    complete_run();
  end

  initial
  begin
    seed = 9327;
    {rst_n, instr_valid, stack_pop, sleep_entered, dog_timeout, avs_read, avs_write} = '0;
    instr_word = '0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = '0;
    bad_count = 0;
    checks_done = 0;
    kicks = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(REG_FLAGS, 32'h0000_0006);
    rd(REG_FETCH, 32'h0);
    rd(REG_STACK, 32'h0);
    // byte lane off and unmapped place
    bus(1'b1, REG_ACC, 32'h0000_005A, 4'h2);
    rd(REG_ACC, 32'h0);
    wr(5'h14, 32'hFFFF_FFFF);
    rd(5'h14, 32'h0);
    // and literal, last pass forces a zero result
    for (int i = 0; i < 5; i++)
    begin
      ra  = 8'($random(seed));
      lit = (i == 4) ? 8'h00 : 8'($random(seed));
      wr(REG_ACC, {24'h0, ra});
      step({OPC_AND_LIT, lit});
      idle();
      rd(REG_ACC, {24'h0, ra & lit});
      rd(REG_FLAGS, {29'h0, 2'b11, (ra & lit) == 8'h00});
    end
    wr(REG_ACC, 32'h0000_00A5);
    wr(REG_FLAGS, 32'h0000_0006);
    step({OPC_ZERO_ACC, 7'($random(seed))});
    idle();
    rd(REG_ACC, 32'h0);
    rd(REG_FLAGS, 32'h0000_0007);
    // bit ops and skips on one file register, back to back
    f = 7'($random(seed));
    b = 3'($random(seed));
    wr(REG_FETCH, 32'h0000_0100);
    wr(REG_ACC, 32'h0000_00FF);
    sleep_entered <= 1'b1;
    dog_timeout   <= 1'b1;
    @(posedge clock);
    sleep_entered <= 1'b0;
    dog_timeout   <= 1'b0;
    step({OPC_ZERO_FILE, f});
    step({OPC_BIT_SET, b, f});
    step({OPC_BIT_SET, b + 3'd1, f});
    step({OPC_BIT_CLEAR, b + 3'd1, f});
    step({OPC_SKIP_CLEAR, b, f});
    step({OPC_AND_LIT, 8'hF0});
    step({OPC_SKIP_SET, b, f});
    step({OPC_AND_LIT, 8'h00});
    step({OPC_SKIP_SET, b + 3'd1, f});
    step({OPC_AND_LIT, 8'h3C});
    step({OPC_SKIP_CLEAR, b + 3'd1, f});
    step({OPC_AND_LIT, 8'h00});
    step({OPC_ZERO_FILE, f});
    step({OPC_SKIP_CLEAR, b, f});
    step({OPC_AND_LIT, 8'h00});
    idle();
    rd(REG_ACC, 32'h0000_0030);
    rd(REG_FETCH, 32'h0000_010F);
    rd(REG_FLAGS, 32'h0000_0001);
    rd(REG_STACK, 32'h0);
    // calls with page bits from the latch
    for (int i = 1; i < 3; i++)
    begin
      lat = 5'($random(seed));
      pc0 = 13'($random(seed));
      k   = 11'($random(seed));
      wr(REG_LATCH, {27'h0, lat});
      wr(REG_FETCH, {19'h0, pc0});
      if (i == 1)
        ret1 = pc0 + 13'd1;
      step({OPC_CALL, k});
      step({OPC_AND_LIT, 8'h00});
      step({OPC_AND_LIT, 8'hFF});
      idle();
      rd(REG_FETCH, {19'h0, {lat[4:3], k} + 13'd1});
      rd(REG_STACK, {13'h0, 3'(i), 3'h0, pc0 + 13'd1});
      rd(REG_ACC, 32'h0000_0030);
    end
    stack_pop <= 1'b1;
    @(posedge clock);
    stack_pop <= 1'b0;
    rd(REG_STACK, {13'h0, 3'd1, 3'h0, ret1});
    kicks = 1;
    step(OPC_KICK);
    idle();
    rd(REG_FLAGS, 32'h0000_0006);
    check_word("kicks_left", 32'h0, 32'(kicks));
    // reset again in mid-run, then the reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(REG_STACK, 32'h0);
    rd(REG_FETCH, 32'h0);
    complete_run();
  end
endmodule // test_bit_literal_call_exec

`default_nettype wire
